// ==== inc/dbh_pkg.sv ====
// Types shared by the debug host serial block
`include "dbh_regs.svh"
`default_nettype none
package dbh_pkg;

  typedef struct packed {
    logic [`DBH_DIV_W-1:0] divisor;
    logic                  seven_bit;
    logic                  two_stop;
  } dbh_line_type;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
  } dbh_word_type;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_STOP  = 5'h08,
    TX_BREAK = 5'h10
  } dbh_tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_STOP  = 5'h08,
    RX_WAIT  = 5'h10
  } dbh_rx_state_type;

endpackage
`default_nettype wire

// ==== inc/dbh_regs.svh ====
// Constants of the debug host serial block
`ifndef DBH_REGS_SVH
`define DBH_REGS_SVH

`define DBH_DIV_W      16
`define DBH_ONE_CNT    16'h0001
`define DBH_ESC_BYTE   8'hFD
`define DBH_BITS_FULL  4'h8
`define DBH_BITS_SHORT 4'h7
`define DBH_FIFO_AW    1

`endif

// ==== rtl/dbh_gfifo.sv ====
// Two-entry buffer with gray-coded pointers between its two sides
`timescale 1ns/1ps
`default_nettype none
`include "dbh_regs.svh"
module dbh_gfifo
(
  // Clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Filling side
  input  wire dbh_pkg::dbh_word_type in_word,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  // Draining side
  output dbh_pkg::dbh_word_type      out_word,
  output logic                       out_valid,
  input  wire logic                  out_ready
);
  localparam int AW = `DBH_FIFO_AW;
  localparam logic [AW:0] FULL_MASK = (AW+1)'(3) << (AW-1);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  dbh_pkg::dbh_word_type mem [2**AW];
  logic [AW:0] wr_bin;
  logic [AW:0] rd_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_gray;
  logic [AW:0] wg_meta;
  logic [AW:0] wg_sync;
  logic [AW:0] rg_meta;
  logic [AW:0] rg_sync;

  wire logic        push        = in_valid && in_ready && ce;
  wire logic        pop         = out_valid && out_ready && ce;
  wire logic [AW:0] next_wr_bin = wr_bin + 1'b1;
  wire logic [AW:0] next_rd_bin = rd_bin + 1'b1;

  // Each side sees the other's pointer only through its gray copy, so
  // full and empty are late by the sync delay but never wrong
  assign in_ready  = (wr_gray != (rg_sync ^ FULL_MASK)); // RQ6
  assign out_valid = (rd_gray != wg_sync);               // RQ6
  assign out_word  = mem[rd_bin[AW-1:0]];

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_bin[AW-1:0]] <= in_word;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_bin  <= '0;
      rd_bin  <= '0;
      wr_gray <= '0;
      rd_gray <= '0;
      wg_meta <= '0;
      wg_sync <= '0;
      rg_meta <= '0;
      rg_sync <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_bin  <= next_wr_bin;
        wr_gray <= to_gray(next_wr_bin);
      end
      if (pop)
      begin
        rd_bin  <= next_rd_bin;
        rd_gray <= to_gray(next_rd_bin);
      end
      wg_meta <= wr_gray;
      wg_sync <= wg_meta;
      rg_meta <= rd_gray;
      rg_sync <= rg_meta;
    end
  end

  chk_gray_step: assert property (@(posedge mclk) disable iff (!resetn) // RQ6
    $countones(wr_gray ^ $past(wr_gray)) <= 1)
    else $error("write pointer moved more than one gray bit");

  cov_fifo_full: cover property (@(posedge mclk) disable iff (!resetn)
    !in_ready ##1 pop);
endmodule
`default_nettype wire

// ==== rtl/dbh_top.sv ====
// Debug host serial block: shared engines, byte router, two channels
`timescale 1ns/1ps
`default_nettype none
`include "dbh_regs.svh"
// How it works
// RQ1: Normal and debug channels share one transmit and one receive engine.
// RQ2: Each channel has its own control logic and its own user port group.
// RQ3: An escape byte steers the next received byte to the debug channel.
// RQ4: Normal channel keeps the usual configurable line and stream ports.
// RQ5: With debug enabled, normal uses debug divisor; other options masked.
// RQ6: Normal receive data passes a FIFO with gray-coded pointers.
// RQ7: Debug characters: start bit zero, eight data bits, stop bit one.
// RQ8: Either side sends break by holding low; break resynchronises routing.
// RQ9: Data bits go least significant bit first.
// RQ10: Line low across a whole frame with stop sets a sticky break flag.
module dbh_top
(
  // Clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Serial pins
  input  wire logic                  rxd,
  output logic                       txd,
  // Normal channel
  input  wire dbh_pkg::dbh_line_type nrm_line,
  input  wire logic [7:0]            nrm_tx_data,
  input  wire logic                  nrm_tx_valid,
  output logic                       nrm_tx_ready,
  input  wire logic                  nrm_break_req,
  output dbh_pkg::dbh_word_type      nrm_rx_word,
  output logic                       nrm_rx_valid,
  input  wire logic                  nrm_rx_ready,
  // Debug channel
  input  wire logic                  dbg_enable,
  input  wire logic [15:0]           dbg_divisor,
  input  wire logic [7:0]            dbg_tx_data,
  input  wire logic                  dbg_tx_valid,
  output logic                       dbg_tx_ready,
  input  wire logic                  dbg_break_req,
  output dbh_pkg::dbh_word_type      dbg_rx_word,
  output logic                       dbg_rx_valid,
  input  wire logic                  dbg_rx_ready,
  // Status
  output logic                       break_flag,
  input  wire logic                  break_clr,
  output logic                       rx_overrun
);
  function automatic logic [15:0] bit_len(input logic [15:0] div);
    bit_len = (div > `DBH_ONE_CNT) ? div - `DBH_ONE_CNT : 16'h0000;
  endfunction

  dbh_pkg::dbh_tx_state_type tx_state;
  dbh_pkg::dbh_tx_state_type next_tx_state;
  dbh_pkg::dbh_rx_state_type rx_state;
  dbh_pkg::dbh_rx_state_type next_rx_state;
  dbh_pkg::dbh_line_type     eff_line;
  dbh_pkg::dbh_word_type     rx_word;
  logic [15:0] tx_cnt;
  logic [15:0] next_tx_cnt;
  logic [7:0]  tx_shift;
  logic [7:0]  next_tx_shift;
  logic [3:0]  tx_left;
  logic [3:0]  next_tx_left;
  logic        next_txd;
  logic        esc_sent;
  logic [15:0] rx_cnt;
  logic [15:0] next_rx_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  next_rx_shift;
  logic [3:0]  rx_left;
  logic [3:0]  next_rx_left;
  logic        rx_seven;
  logic        next_rx_seven;
  logic        rx_meta;
  logic        rx_s2;
  logic        rx_s3;
  logic        rx_filt;
  logic        route_esc;
  logic        nrm_in_ready;
  logic        dbg_in_ready;

  // When debug owns the line the normal channel cannot pick 7 bits or
  // two stops, else the host would lose framing on interleaved bytes
  wire dbh_pkg::dbh_line_type dbg_line = '{divisor:   dbg_divisor,
                                           seven_bit: 1'b0,
                                           two_stop:  1'b0};
  assign eff_line = dbg_enable ? dbg_line : nrm_line; // RQ5 RQ4

  // Transmit side selection
  wire logic       brk_req  = nrm_break_req || (dbg_enable && dbg_break_req);
  wire logic       tx_idle  = (tx_state == dbh_pkg::TX_IDLE) && !brk_req;
  wire logic       ld_dbg   = tx_idle && dbg_enable && dbg_tx_valid;
  wire logic       ld_nrm   = tx_idle && nrm_tx_valid && !ld_dbg;
  wire logic       ld_any   = ld_dbg || ld_nrm;
  wire logic [7:0] ld_byte  = ld_nrm ? nrm_tx_data
                            : (esc_sent ? dbg_tx_data : `DBH_ESC_BYTE);
  wire logic [3:0] ld_bits  = eff_line.seven_bit ? `DBH_BITS_SHORT
                                                 : `DBH_BITS_FULL;
  wire logic       tx_tick  = (tx_cnt == 16'h0000);
  wire logic [15:0] reload  = bit_len(eff_line.divisor);

  assign dbg_tx_ready = ld_dbg && esc_sent && ce; // RQ1
  assign nrm_tx_ready = ld_nrm && ce;             // RQ1

  always_comb
  begin
    next_tx_state = tx_state;
    next_txd      = txd;
    next_tx_cnt   = tx_tick ? reload : tx_cnt - `DBH_ONE_CNT;
    next_tx_shift = tx_shift;
    next_tx_left  = tx_left;
    unique case (tx_state)
      dbh_pkg::TX_IDLE:
        if (brk_req)
        begin
          next_tx_state = dbh_pkg::TX_BREAK; // RQ8
          next_txd      = 1'b0;
        end
        else if (ld_any)
        begin
          next_tx_state = dbh_pkg::TX_START; // RQ7
          next_txd      = 1'b0;
          next_tx_cnt   = reload;
          next_tx_shift = ld_byte;
          next_tx_left  = ld_bits - 4'h1;
        end
      dbh_pkg::TX_START:
        if (tx_tick)
        begin
          next_tx_state = dbh_pkg::TX_DATA;
          next_txd      = tx_shift[0]; // RQ9
          next_tx_shift = {1'b0, tx_shift[7:1]};
        end
      dbh_pkg::TX_DATA:
        if (tx_tick && tx_left == 4'h0)
        begin
          next_tx_state = dbh_pkg::TX_STOP; // RQ7
          next_txd      = 1'b1;
          next_tx_left  = {3'h0, eff_line.two_stop};
        end
        else if (tx_tick)
        begin
          next_txd      = tx_shift[0]; // RQ9
          next_tx_shift = {1'b0, tx_shift[7:1]};
          next_tx_left  = tx_left - 4'h1;
        end
      dbh_pkg::TX_STOP:
        if (tx_tick && tx_left != 4'h0)
          next_tx_left = tx_left - 4'h1;
        else if (tx_tick)
          next_tx_state = dbh_pkg::TX_IDLE;
      dbh_pkg::TX_BREAK:
        // One stop time of mark follows a break so the far end rearms
        if (!brk_req)
        begin
          next_tx_state = dbh_pkg::TX_STOP; // RQ8
          next_txd      = 1'b1;
          next_tx_cnt   = reload;
          next_tx_left  = 4'h0;
        end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state <= dbh_pkg::TX_IDLE;
      txd      <= 1'b1;
      tx_cnt   <= 16'h0000;
      tx_shift <= 8'h00;
      tx_left  <= 4'h0;
      esc_sent <= 1'b0;
    end
    else if (ce)
    begin
      tx_state <= next_tx_state;
      txd      <= next_txd;
      tx_cnt   <= next_tx_cnt;
      tx_shift <= next_tx_shift;
      tx_left  <= next_tx_left;
      esc_sent <= dbg_enable && (esc_sent ^ ld_dbg); // RQ3
    end
  end

  // Receive side
  wire logic       rx_tick  = (rx_cnt == 16'h0000);
  wire logic [7:0] rx_byte  = rx_seven ? {1'b0, rx_shift[7:1]} : rx_shift;
  wire logic       rx_end   = (rx_state == dbh_pkg::RX_STOP) && rx_tick && ce;
  wire logic       brk_evt  = rx_end && !rx_filt && (rx_byte == 8'h00);
  wire logic       rx_done  = rx_end && !brk_evt;
  // Only a finished frame may arm steering: the shifter passes through
  // escape-like values mid-frame and keeps the last byte afterwards
  wire logic       esc_hit  = rx_done && dbg_enable && !route_esc
                           && (rx_byte == `DBH_ESC_BYTE);
  wire logic       dbg_push = rx_done && route_esc;            // RQ3
  wire logic       nrm_push = rx_done && !route_esc && !esc_hit; // RQ3

  assign rx_word = '{data: rx_byte, frame_err: !rx_filt};

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_tick ? reload : rx_cnt - `DBH_ONE_CNT;
    next_rx_shift = rx_shift;
    next_rx_left  = rx_left;
    next_rx_seven = rx_seven;
    unique case (rx_state)
      dbh_pkg::RX_IDLE:
        if (!rx_filt)
        begin
          next_rx_state = dbh_pkg::RX_START;
          next_rx_cnt   = bit_len({1'b0, eff_line.divisor[15:1]});
          next_rx_seven = eff_line.seven_bit;
        end
      dbh_pkg::RX_START:
        if (rx_tick)
        begin
          next_rx_state = rx_filt ? dbh_pkg::RX_IDLE : dbh_pkg::RX_DATA;
          next_rx_left  = (rx_seven ? `DBH_BITS_SHORT : `DBH_BITS_FULL)
                        - 4'h1;
        end
      dbh_pkg::RX_DATA:
        if (rx_tick)
        begin
          next_rx_shift = {rx_filt, rx_shift[7:1]}; // RQ9
          next_rx_left  = rx_left - 4'h1;
          if (rx_left == 4'h0)
            next_rx_state = dbh_pkg::RX_STOP;
        end
      dbh_pkg::RX_STOP:
        if (rx_tick)
          next_rx_state = (brk_evt) ? dbh_pkg::RX_WAIT // RQ10
                                    : dbh_pkg::RX_IDLE;
      dbh_pkg::RX_WAIT:
        if (rx_filt)
          next_rx_state = dbh_pkg::RX_IDLE; // RQ8
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_meta    <= 1'b1;
      rx_s2      <= 1'b1;
      rx_s3      <= 1'b1;
      rx_filt    <= 1'b1;
      rx_state   <= dbh_pkg::RX_IDLE;
      rx_cnt     <= 16'h0000;
      rx_shift   <= 8'h00;
      rx_left    <= 4'h0;
      rx_seven   <= 1'b0;
      route_esc  <= 1'b0;
      break_flag <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else if (ce)
    begin
      rx_meta    <= rxd;
      rx_s2      <= rx_meta;
      rx_s3      <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_filt  <= rx_s3;
      rx_state   <= next_rx_state;
      rx_cnt     <= next_rx_cnt;
      rx_shift   <= next_rx_shift;
      rx_left    <= next_rx_left;
      rx_seven   <= next_rx_seven;
      // A break drops any half-received escape so both ends restart clean
      route_esc  <= dbg_enable && !brk_evt && !dbg_push
                  && (route_esc || esc_hit);            // RQ8 RQ3
      break_flag <= brk_evt || (break_flag && !break_clr); // RQ10
      rx_overrun <= (nrm_push && !nrm_in_ready)
                 || (dbg_push && !dbg_in_ready);
    end
  end

  dbh_gfifo u_nrm_fifo
  (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .in_word   (rx_word),
    .in_valid  (nrm_push),
    .in_ready  (nrm_in_ready),
    .out_word  (nrm_rx_word),
    .out_valid (nrm_rx_valid),
    .out_ready (nrm_rx_ready)
  ); // RQ6

  dbh_gfifo u_dbg_fifo
  (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .in_word   (rx_word),
    .in_valid  (dbg_push),
    .in_ready  (dbg_in_ready),
    .out_word  (dbg_rx_word),
    .out_valid (dbg_rx_valid),
    .out_ready (dbg_rx_ready)
  ); // RQ2

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_start_low: assert property ( // RQ7
    tx_state == dbh_pkg::TX_START |-> !txd)
    else $error("start bit not low");
  chk_stop_high: assert property ( // RQ7
    tx_state == dbh_pkg::TX_STOP |-> txd)
    else $error("stop bit not high");
  chk_lsb_first: assert property ( // RQ9
    tx_state == dbh_pkg::TX_START && tx_tick && ce |=>
      txd == $past(tx_shift[0]))
    else $error("first data bit is not bit zero");
  chk_break_hold: assert property ( // RQ8
    tx_state == dbh_pkg::TX_BREAK && brk_req |=> !txd)
    else $error("line released during break");
  chk_break_flag: assert property ( // RQ10
    brk_evt |=> break_flag && rx_state == dbh_pkg::RX_WAIT)
    else $error("break not flagged");
  chk_escape_route: assert property ( // RQ3
    rx_done && esc_hit |-> !nrm_push ##1 route_esc)
    else $error("escape byte leaked to normal channel");
  chk_debug_eight: assert property ( // RQ5
    dbg_enable && ld_any && ce |=> tx_left == 4'h7)
    else $error("debug framing not eight bits");
  chk_one_engine: assert property ( // RQ1
    !(nrm_tx_ready && dbg_tx_ready))
    else $error("both channels took the transmitter");
  chk_dbg_lane: assert property ( // RQ2
    rx_done && route_esc |-> dbg_push && !nrm_push)
    else $error("escaped byte not given to debug channel");

  cov_dbg_tx: cover property (dbg_tx_ready);
  cov_break_rx: cover property (brk_evt);
  cov_nrm_rx: cover property (nrm_push ##[1:20] nrm_rx_valid);
  cov_dbg_rx: cover property (dbg_push);
endmodule
`default_nettype wire

// ==== sim/dbh_host.sv ====
// PC host model: 8-N-1 serial sender, break sender and frame receiver
`timescale 1ns/1ps
`default_nettype none
module dbh_host
#(
  parameter int BIT_CYC = 8
)
(
  // Clock
  input  wire logic mclk,
  // Serial lines seen from the host
  input  wire logic dev_txd,
  output logic      dev_rxd
);
  logic [8:0] got_q [$];

  initial dev_rxd = 1'b1;

  // Stop level is a choice so that framing faults can be commanded
  task automatic send(input logic [7:0] b, input logic stp);
    begin
      for (int i = 0; i < 10; i++)
      begin
        dev_rxd <= (i == 0) ? 1'b0 : ((i == 9) ? stp : b[i-1]);
        repeat (BIT_CYC) @(posedge mclk);
      end
      dev_rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask

  task automatic brk(input int bits);
    begin
      dev_rxd <= 1'b0;
      repeat (bits * BIT_CYC) @(posedge mclk);
      dev_rxd <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge mclk);
    end
  endtask

  // Words are kept as data then stop level; a break shows as a low stop
  always
  begin : rx_proc
    logic [8:0] w;
    @(negedge dev_txd);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CYC) @(posedge mclk);
      w[i] = dev_txd;
    end
    got_q.push_back({w[7:0], w[8]});
    wait (dev_txd === 1'b1);
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the debug host serial block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic       en;
    logic       dbg;
    logic [7:0] b;
    logic       stp;
    logic       fe;
  } dbh_row_type;

  localparam int BC  = 8;
  localparam int LIM = 3000;
  logic                  mclk, resetn, ce, rxd, txd;
  dbh_pkg::dbh_line_type nrm_line;
  logic [15:0]           dbg_divisor;
  logic [7:0]            nrm_tx_data, dbg_tx_data;
  logic                  nrm_tx_valid, nrm_tx_ready, nrm_break_req;
  logic                  dbg_tx_valid, dbg_tx_ready, dbg_break_req;
  dbh_pkg::dbh_word_type nrm_rx_word, dbg_rx_word;
  logic                  nrm_rx_valid, nrm_rx_ready, dbg_rx_valid;
  logic                  dbg_rx_ready, dbg_enable;
  logic                  break_flag, break_clr, rx_overrun;
  int                    errors, cmp_count, ovr_cnt;
  logic [8:0]            hw;
  dbh_row_type           rows [7];

  dbh_top i_dut
  (
    .mclk(mclk), .resetn(resetn), .ce(ce), .rxd(rxd), .txd(txd),
    .nrm_line(nrm_line), .nrm_tx_data(nrm_tx_data),
    .nrm_tx_valid(nrm_tx_valid), .nrm_tx_ready(nrm_tx_ready),
    .nrm_break_req(nrm_break_req), .nrm_rx_word(nrm_rx_word),
    .nrm_rx_valid(nrm_rx_valid), .nrm_rx_ready(nrm_rx_ready),
    .dbg_enable(dbg_enable), .dbg_divisor(dbg_divisor),
    .dbg_tx_data(dbg_tx_data), .dbg_tx_valid(dbg_tx_valid),
    .dbg_tx_ready(dbg_tx_ready), .dbg_break_req(dbg_break_req),
    .dbg_rx_word(dbg_rx_word), .dbg_rx_valid(dbg_rx_valid),
    .dbg_rx_ready(dbg_rx_ready), .break_flag(break_flag),
    .break_clr(break_clr), .rx_overrun(rx_overrun)
  );

  dbh_host #(.BIT_CYC(BC)) i_host
  (
    .mclk(mclk), .dev_txd(txd), .dev_rxd(rxd)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (rx_overrun === 1'b1)
      ovr_cnt++;

  task automatic stop_test;
    begin
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    begin
      cmp_count++;
      if (g !== e)
      begin
        errors++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task automatic step(inout int n);
    begin
      @(posedge mclk);
      n++;
      if (n > LIM)
      begin
        errors++;
        $display("mismatch wait expected done seen timeout");
        stop_test();
      end
    end
  endtask

  // Word and the other channel's valid are both looked at one edge before the take edge
  task automatic get_word(input logic ch, input logic [8:0] e);
    int n;
    begin
      n = 0;
      do step(n); while ((ch ? dbg_rx_valid : nrm_rx_valid) !== 1'b1);
      chk("rx word", e, ch ? dbg_rx_word : nrm_rx_word);
      chk("other valid", 9'h000,
          {8'h00, ch ? nrm_rx_valid : dbg_rx_valid});
      dbg_rx_ready <= ch;
      nrm_rx_ready <= ~ch;
      @(posedge mclk);
      dbg_rx_ready <= 1'b0;
      nrm_rx_ready <= 1'b0;
    end
  endtask

  task automatic put_tx(input logic ch, input logic [7:0] b);
    int n;
    begin
      n = 0;
      dbg_tx_data  <= b;
      nrm_tx_data  <= b;
      dbg_tx_valid <= ch;
      nrm_tx_valid <= ~ch;
      do step(n); while ((ch ? dbg_tx_ready : nrm_tx_ready) !== 1'b1);
      dbg_tx_valid <= 1'b0;
      nrm_tx_valid <= 1'b0;
    end
  endtask

  task automatic host_word(input logic [8:0] e);
    int n;
    begin
      n = 0;
      while (i_host.got_q.size() == 0)
        step(n);
      hw = i_host.got_q.pop_front();
      chk("host word", e, hw);
    end
  endtask

  initial
  begin
    errors        = 0;
    cmp_count     = 0;
    ovr_cnt       = 0;
    resetn        = 1'b0;
    ce            = 1'b1;
    nrm_line      = {16'h0008, 2'b00};
    dbg_divisor   = 16'h0008;
    nrm_tx_data   = 8'h00;
    dbg_tx_data   = 8'h00;
    nrm_tx_valid  = 1'b0;
    dbg_tx_valid  = 1'b0;
    nrm_break_req = 1'b0;
    dbg_break_req = 1'b0;
    nrm_rx_ready  = 1'b0;
    dbg_rx_ready  = 1'b0;
    dbg_enable    = 1'b0;
    break_clr     = 1'b0;
    // Odd normal settings in debug rows must be masked by the block
    rows = '{{1'b0, 1'b0, 8'h41, 1'b1, 1'b0},
             {1'b0, 1'b0, 8'hFD, 1'b1, 1'b0},
             {1'b1, 1'b0, 8'hC5, 1'b1, 1'b0},
             {1'b1, 1'b1, 8'h5A, 1'b1, 1'b0},
             {1'b1, 1'b1, 8'hFD, 1'b1, 1'b0},
             {1'b0, 1'b0, 8'h80, 1'b0, 1'b1},
             {1'b1, 1'b1, 8'h01, 1'b0, 1'b1}};
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk("txd idle", 9'h001, {8'h00, txd});
    chk("rx valids", 9'h000, {7'h00, nrm_rx_valid, dbg_rx_valid});
    chk("break flag", 9'h000, {8'h00, break_flag});
    // Enable low must keep the idle engine off a waiting byte
    ce           <= 1'b0;
    nrm_tx_data  <= 8'h55;
    nrm_tx_valid <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("frozen ready", 9'h000, {8'h00, nrm_tx_ready});
    chk("frozen txd", 9'h001, {8'h00, txd});
    ce           <= 1'b1;
    nrm_tx_valid <= 1'b0;
    $display("test reset done");

    foreach (rows[i])
    begin
      dbg_enable <= rows[i].en;
      nrm_line   <= rows[i].en ? {16'h0010, 2'b11} : {16'h0008, 2'b00};
      @(posedge mclk);
      if (rows[i].dbg)
        i_host.send(8'hFD, 1'b1);
      i_host.send(rows[i].b, rows[i].stp);
      get_word(rows[i].dbg, {rows[i].b, rows[i].fe});
    end
    $display("test rows done");

    dbg_enable <= 1'b1;
    nrm_line   <= {16'h0010, 2'b11};
    put_tx(1'b0, 8'hA3);
    host_word({8'hA3, 1'b1});
    put_tx(1'b1, 8'h3C);
    host_word({8'hFD, 1'b1});
    host_word({8'h3C, 1'b1});
    $display("test transmit done");

    // A break after an escape must drop the pending debug steering
    i_host.send(8'hFD, 1'b1);
    i_host.brk(12);
    chk("break set", 9'h001, {8'h00, break_flag});
    chk("no word", 9'h000, {7'h00, nrm_rx_valid, dbg_rx_valid});
    break_clr <= 1'b1;
    @(posedge mclk);
    break_clr <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("break clear", 9'h000, {8'h00, break_flag});
    i_host.send(8'h22, 1'b1);
    get_word(1'b0, {8'h22, 1'b0});
    $display("test break receive done");

    // Receiver stalls so the third byte finds the buffer full
    dbg_enable <= 1'b0;
    nrm_line   <= {16'h0008, 2'b00};
    ovr_cnt = 0;
    i_host.send(8'h11, 1'b1);
    i_host.send(8'h22, 1'b1);
    i_host.send(8'h33, 1'b1);
    repeat (8) @(posedge mclk);
    chk("overrun count", 9'h001, 9'(ovr_cnt));
    get_word(1'b0, {8'h11, 1'b0});
    get_word(1'b0, {8'h22, 1'b0});
    repeat (8) @(posedge mclk);
    chk("drained", 9'h000, {8'h00, nrm_rx_valid});
    $display("test buffer done");

    // Seven bits, two stops: host sees bit 7 and its stop as marks
    nrm_line <= {16'h0008, 2'b11};
    @(posedge mclk);
    i_host.send(8'hB5, 1'b1);
    get_word(1'b0, {8'h35, 1'b0});
    put_tx(1'b0, 8'h35);
    host_word({8'hB5, 1'b1});
    nrm_line <= {16'h0008, 2'b00};
    $display("test seven bit done");

    dbg_enable <= 1'b1;
    for (int c = 0; c < 2; c++)
    begin
      dbg_break_req <= (c == 1);
      nrm_break_req <= (c == 0);
      repeat (5 * BC) @(posedge mclk);
      chk("break txd", 9'h000, {8'h00, txd});
      dbg_break_req <= 1'b0;
      nrm_break_req <= 1'b0;
      repeat (4 * BC) @(posedge mclk);
      chk("mark txd", 9'h001, {8'h00, txd});
      repeat (10 * BC) @(posedge mclk);
      i_host.got_q.delete();
    end
    $display("test break send done");
    stop_test();
  end
endmodule
`default_nettype wire
